/* File: verilog/bme_map.svh */
// constant map of the bit manipulation execute block
`ifndef BME_MAP_SVH
`define BME_MAP_SVH
// first-word form nibble (opcode bits 15..12)
`define BME_FORM_REG_IMM 4'h7
`define BME_FORM_REG_RM 4'h6
`define BME_FORM_IND 4'h5
`define BME_FORM_ABS 4'h4
// second-word bit source nibble (bits 15..12)
`define BME_SRC_IMM 4'h7
`define BME_SRC_RM 4'h6
// field positions
`define BME_OP_HI 15
`define BME_OP_LO 8
`define BME_FLD_HI 7
`define BME_FLD_LO 4
// absolute short page and on-chip port addresses
`define BME_ABS_PAGE 8'hFF
`define BME_DIR_ADDR 16'hFFC4
`define BME_LATCH_ADDR 16'hFFC6
// reset values and read-back of write-only bytes
`define BME_DIR_RST 8'h00
`define BME_LATCH_RST 8'h00
`define BME_WO_READ 8'hFF
`endif

/* File: verilog/bme_pkg.sv */
// types of the bit manipulation execute block
package bme_pkg;
    typedef enum logic [2:0]
    {
        BME_IDLE = 3'h0,
        BME_READ = 3'h1,
        BME_MODIFY = 3'h3,
        BME_WRITE = 3'h2,
        BME_DONE = 3'h6
    } bme_state_e;
    typedef enum logic [3:0]
    {
        BME_SET = 4'h0,
        BME_CLR = 4'h1,
        BME_INV = 4'h2,
        BME_TST = 4'h3,
        BME_AND = 4'h4,
        BME_IAND = 4'h5,
        BME_OR = 4'h6,
        BME_IOR = 4'h7,
        BME_XOR = 4'h8,
        BME_IXOR = 4'h9,
        BME_LD = 4'hA,
        BME_ILD = 4'hB,
        BME_ST = 4'hC,
        BME_IST = 4'hD
    } bme_kind_e;
    typedef struct packed
    {
        logic [15:0] w0;
        logic [15:0] w1;
    } bme_instr_s;
    typedef struct packed
    {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } bme_bus_s;
endpackage

/* File: verilog/bme_port.sv */
// port direction register and output latch with pin drive
`timescale 1ns/1ps
`include "bme_map.svh"
module bme_port
    import bme_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic wr_i,
    input wire logic [15:0] addr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    output logic hit_o,
    output logic [WIDTH-1:0] rdata_o,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] pin_o,
    output logic [WIDTH-1:0] pin_oe_o
);
    logic [WIDTH-1:0] dir_ff;
    logic [WIDTH-1:0] latch_ff;
    wire sel_dir = (addr_i == `BME_DIR_ADDR);
    wire sel_latch = (addr_i == `BME_LATCH_ADDR);
    // ----------------------------------------
    // decode and read-back
    // ----------------------------------------
    assign hit_o = sel_dir | sel_latch;
    // direction byte is write-only and reads as all ones
    assign rdata_o = sel_dir ? WIDTH'(`BME_WO_READ) : latch_ff;
    // direction bit 1 drives the latch out, 0 leaves the pin an input
    assign pin_o = latch_ff;
    assign pin_oe_o = dir_ff;
    // register writes
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            dir_ff <= WIDTH'(`BME_DIR_RST);
            latch_ff <= WIDTH'(`BME_LATCH_RST);
        end
        else if (wr_i)
        begin
            if (sel_dir)
                dir_ff <= wdata_i;
            if (sel_latch)
                latch_ff <= wdata_i;
        end
    end
    // the pins themselves are not looked at inside this block
    wire unused_pins = ^pin_i;
endmodule

/* File: verilog/bme_exec.sv */
// execute unit for single-bit instructions on registers and memory bytes
`timescale 1ns/1ps
`include "bme_map.svh"
module bme_exec
    import bme_pkg::*;
(
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic instr_valid_i,
    input wire bme_instr_s instr_i,
    output logic instr_ready_o,
    output logic done_o,
    output logic illegal_o,
    output logic carry_o,
    output logic zero_o,
    input wire logic gr_we_i,
    input wire logic [3:0] gr_idx_i,
    input wire logic [7:0] gr_wdata_i,
    output logic [7:0] gr_rdata_o,
    output bme_bus_s bus_o,
    input wire logic [7:0] bus_rdata_i,
    input wire logic bus_ack_i,
    input wire logic [7:0] pin_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_o
);
    bme_state_e state_ff, nxt_state;
    bme_kind_e kind_ff;
    logic [2:0] bit_ff;
    logic [3:0] reg_ff;
    logic is_reg_ff;
    logic [15:0] addr_ff;
    logic [7:0] data_ff;
    logic carry_ff, zero_ff, illegal_ff;
    logic [15:0] gr_ff [8];
    // ----------------------------------------
    // decode of the instruction words
    // ----------------------------------------
    // form from the first opcode byte, operation from its low nibble or, in two-word forms, from bits 11..8 of the second word
    wire [7:0] op0 = instr_i.w0[`BME_OP_HI:`BME_OP_LO];
    wire [3:0] form = op0[7:4];
    wire [3:0] fld0 = instr_i.w0[`BME_FLD_HI:`BME_FLD_LO];
    wire [3:0] fld1 = instr_i.w1[`BME_FLD_HI:`BME_FLD_LO];
    wire two_word = (form == `BME_FORM_IND) | (form == `BME_FORM_ABS);
    wire [3:0] kind_in = two_word ? instr_i.w1[11:8] : op0[3:0];
    wire from_rm = two_word ? (instr_i.w1[15:12] == `BME_SRC_RM) : (form == `BME_FORM_REG_RM);
    // operand register sits in the low nibble of the register-direct word
    wire [3:0] rn_sel = instr_i.w0[3:0];
    wire [3:0] rm_sel = two_word ? fld1 : fld0;
    // byte register select: bit 3 picks the low half of a word register
    function automatic logic [7:0] gr_byte(input logic [15:0] w, input logic lo);
        gr_byte = lo ? w[7:0] : w[15:8];
    endfunction
    wire [7:0] rm_byte = gr_byte(gr_ff[rm_sel[2:0]], rm_sel[3]);
    wire [7:0] rn_byte = gr_byte(gr_ff[rn_sel[2:0]], rn_sel[3]);
    // bit number from an immediate field or the low three bits of a register
    wire [2:0] bit_in = from_rm ? rm_byte[2:0] : (two_word ? fld1[2:0] : fld0[2:0]);
    wire inv_kind = kind_in[0] & (kind_in >= 4'h5) & (kind_in <= 4'hD);
    // only forms 4 to 7 are decoded, everything else is refused
    wire bad_form = (form < `BME_FORM_ABS) | (form > `BME_FORM_REG_IMM);
    wire bad_kind = (kind_in > 4'hD);
    // inverted-operand kinds never take the bit number from a register
    wire bad_src = inv_kind & from_rm;
    wire bad_pad = two_word & (instr_i.w1[3:0] != 4'h0);
    wire bad_src_nib = two_word & ~from_rm & (instr_i.w1[15:12] != `BME_SRC_IMM);
    wire bad = bad_form | bad_kind | bad_src | bad_pad | bad_src_nib;
    // effective address: register pointer or short absolute page
    wire [15:0] ea_in = (form == `BME_FORM_IND) ? gr_ff[fld0[2:0]] : {`BME_ABS_PAGE, instr_i.w0[7:0]};
    wire take = instr_valid_i & (state_ff == BME_IDLE);
    // ----------------------------------------
    // bit arithmetic
    // ----------------------------------------
    wire [7:0] mask = 8'h01 << bit_ff;
    wire sel_bit = data_ff[bit_ff];
    // store kinds write the carry or its inverse into the bit
    wire st_val = (kind_ff == BME_IST) ? ~carry_ff : carry_ff;
    logic [7:0] new_byte;
    logic nxt_carry;
    logic nxt_zero;
    // only the selected bit changes, all others keep their fetched value
    always_comb
    begin
        new_byte = data_ff;
        nxt_carry = carry_ff;
        nxt_zero = zero_ff;
        case (kind_ff)
            BME_SET: new_byte = data_ff | mask;
            BME_CLR: new_byte = data_ff & ~mask;
            BME_INV: new_byte = data_ff ^ mask;
            BME_TST: nxt_zero = ~sel_bit;
            BME_AND: nxt_carry = carry_ff & sel_bit;
            BME_IAND: nxt_carry = carry_ff & ~sel_bit;
            BME_OR: nxt_carry = carry_ff | sel_bit;
            BME_IOR: nxt_carry = carry_ff | ~sel_bit;
            BME_XOR: nxt_carry = carry_ff ^ sel_bit;
            BME_IXOR: nxt_carry = carry_ff ^ ~sel_bit;
            BME_LD: nxt_carry = sel_bit;
            BME_ILD: nxt_carry = ~sel_bit;
            BME_ST, BME_IST: new_byte = st_val ? (data_ff | mask) : (data_ff & ~mask);
            default: new_byte = data_ff;
        endcase
    end
    // set, clear, invert and the stores are the writing kinds
    wire writes = (kind_ff <= BME_INV) | (kind_ff == BME_ST) | (kind_ff == BME_IST);
    // ----------------------------------------
    // on-chip port and bus selection
    // ----------------------------------------
    logic port_hit;
    logic [7:0] port_rdata;
    wire port_wr = (state_ff == BME_WRITE) & port_hit;
    bme_port #(
        .WIDTH(8)
    ) u_port (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .wr_i(port_wr),
        .addr_i(addr_ff),
        .wdata_i(data_ff),
        .hit_o(port_hit),
        .rdata_o(port_rdata),
        .pin_i(pin_i),
        .pin_o(pin_o),
        .pin_oe_o(pin_oe_o)
    );
    // on-chip port bytes answer at once, others wait for the bus
    wire mem_cycle = (state_ff == BME_READ) | (state_ff == BME_WRITE);
    wire ack = port_hit | bus_ack_i;
    wire [7:0] rd_byte = port_hit ? port_rdata : bus_rdata_i;
    assign bus_o.req = mem_cycle & ~port_hit;
    assign bus_o.we = (state_ff == BME_WRITE) & ~port_hit;
    assign bus_o.addr = addr_ff;
    assign bus_o.wdata = data_ff;
    // ----------------------------------------
    // sequencer: read, modify, write
    // ----------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            BME_IDLE:
                if (take)
                    nxt_state = bad ? BME_DONE : (two_word ? BME_READ : BME_MODIFY);
            BME_READ:
                if (ack)
                    nxt_state = BME_MODIFY;
            BME_MODIFY:
                nxt_state = (writes & ~is_reg_ff) ? BME_WRITE : BME_DONE;
            BME_WRITE:
                if (ack)
                    nxt_state = BME_DONE;
            BME_DONE:
                nxt_state = BME_IDLE;
            default:
                nxt_state = BME_IDLE;
        endcase
    end
    assign instr_ready_o = (state_ff == BME_IDLE);
    assign done_o = (state_ff == BME_DONE);
    assign illegal_o = done_o & illegal_ff;
    assign carry_o = carry_ff;
    assign zero_o = zero_ff;
    // state and operand capture
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            state_ff <= BME_IDLE;
            kind_ff <= BME_TST;
            bit_ff <= 3'h0;
            reg_ff <= 4'h0;
            is_reg_ff <= 1'b0;
            addr_ff <= 16'h0000;
            data_ff <= 8'h00;
            illegal_ff <= 1'b0;
            carry_ff <= 1'b0;
            zero_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            if (take)
            begin
                kind_ff <= bme_kind_e'(kind_in);
                bit_ff <= bit_in;
                reg_ff <= rn_sel;
                is_reg_ff <= ~two_word;
                addr_ff <= ea_in;
                data_ff <= rn_byte;
                illegal_ff <= bad;
            end
            // whole byte fetched; a write-only byte comes back as ones
            if ((state_ff == BME_READ) & ack)
                data_ff <= rd_byte;
            if (state_ff == BME_MODIFY)
            begin
                data_ff <= new_byte;
                carry_ff <= nxt_carry;
                zero_ff <= nxt_zero;
            end
        end
    end
    // ----------------------------------------
    // general registers
    // ----------------------------------------
    wire reg_wb = (state_ff == BME_MODIFY) & is_reg_ff & writes;
    for (genvar g = 0; g < 8; g++)
    begin : g_gr
        wire hit_in = reg_wb & (reg_ff[2:0] == 3'(g));
        wire hit_ext = gr_we_i & (gr_idx_i[2:0] == 3'(g));
        wire [3:0] idx = hit_in ? reg_ff : gr_idx_i;
        wire [7:0] wb = hit_in ? new_byte : gr_wdata_i;
        always_ff @(posedge clock_i)
        begin
            if (!nrst_i)
                gr_ff[g] <= 16'h0000;
            else if (hit_in | hit_ext)
                gr_ff[g] <= idx[3] ? {gr_ff[g][15:8], wb} : {wb, gr_ff[g][7:0]};
        end
    end
    // read-back register byte for software view
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
            gr_rdata_o <= 8'h00;
        else
            gr_rdata_o <= gr_byte(gr_ff[gr_idx_i[2:0]], gr_idx_i[3]);
    end
    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    sequence s_fetch;
        (state_ff == BME_READ) && ack;
    endsequence
    sequence s_modify;
        state_ff == BME_MODIFY;
    endsequence
    wr_after_read_a: assert property ((state_ff == BME_WRITE) && !$past(state_ff == BME_WRITE)
        |-> $past(state_ff == BME_MODIFY) && $past(state_ff, 2) == BME_READ)
        else $error("write issued without a preceding fetch");
    wo_reads_ones_a: assert property (s_fetch and (addr_ff == `BME_DIR_ADDR)
        |=> data_ff == `BME_WO_READ)
        else $error("write-only byte not read as ones");
    one_bit_change_a: assert property (s_fetch ##1 s_modify ##1 (state_ff == BME_WRITE)
        |-> $countones(data_ff ^ $past(data_ff)) <= 1)
        else $error("more than one bit changed");
    same_addr_a: assert property (s_fetch |=> ##1 $stable(addr_ff))
        else $error("write-back address moved");
    pin_dir_a: assert property (port_wr && (addr_ff == `BME_DIR_ADDR) |=> pin_oe_o == $past(data_ff))
        else $error("pin enable not following direction byte");
    dir_ones_a: assert property ((state_ff == BME_WRITE) && port_hit && (addr_ff == `BME_DIR_ADDR)
        && kind_ff == BME_CLR |=> pin_oe_o == (8'hFF & ~mask))
        else $error("direction write-back lost read ones");
    inv_imm_only_a: assert property (take && inv_kind && from_rm |=> illegal_ff)
        else $error("inverted kind accepted register bit number");
    pad_zero_a: assert property (take && bad_pad |=> state_ff == BME_DONE ##0 illegal_o)
        else $error("nonzero low nibble accepted");
    test_zero_a: assert property (s_modify and (kind_ff == BME_TST)
        |=> zero_ff == !$past(sel_bit) && state_ff == BME_DONE)
        else $error("bit test zero flag wrong");
    carry_and_a: assert property (s_modify and (kind_ff == BME_AND)
        |=> carry_ff == ($past(carry_ff) & $past(sel_bit)))
        else $error("carry and result wrong");
    no_write_a: assert property (s_modify and !writes |=> !bus_o.we [*2])
        else $error("read-only kind issued a write");
    bit_range_a: assert property (take && from_rm |=> bit_ff == $past(rm_byte[2:0]))
        else $error("register bit number not low three bits");
    reg_direct_a: assert property (take && !bad && !two_word |=> s_modify ##1 (state_ff == BME_DONE))
        else $error("register form not single pass");
endmodule

/* File: testbench/bme_mem_model.sv */
// memory model on the far side of the execute unit's data bus
`timescale 1ns/1ps
module bme_mem_model
    import bme_pkg::*;
(
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire bme_bus_s bus_i,
    input wire logic [3:0] wait_i,
    output logic [7:0] rdata_o,
    output logic ack_o,
    output logic [15:0] rd_cnt_o,
    output logic [15:0] wr_cnt_o,
    output logic order_err_o
);
    logic [7:0] mem [0:255];
    logic [3:0] cnt_ff;
    logic [15:0] last_rd_ff;
    logic rd_pend_ff;

    // answer after wait_i stall cycles; read data only valid with the ack
    always @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            ack_o <= 1'b0;
            cnt_ff <= 4'h0;
            rdata_o <= 8'hA5;
            rd_cnt_o <= 16'h0000;
            wr_cnt_o <= 16'h0000;
            order_err_o <= 1'b0;
            rd_pend_ff <= 1'b0;
            last_rd_ff <= 16'h0000;
        end
        else if (bus_i.req && !ack_o && cnt_ff < wait_i)
        begin
            cnt_ff <= cnt_ff + 4'h1;
            rdata_o <= ~rdata_o; // no stale data while stalling
        end
        else if (bus_i.req && !ack_o)
        begin
            ack_o <= 1'b1;
            cnt_ff <= 4'h0;
            if (bus_i.we)
            begin
                mem[bus_i.addr[7:0]] <= bus_i.wdata;
                wr_cnt_o <= wr_cnt_o + 16'h0001;
                // a write must follow a read of the same byte
                if (!rd_pend_ff || bus_i.addr != last_rd_ff)
                    order_err_o <= 1'b1;
                rd_pend_ff <= 1'b0;
            end
            else
            begin
                rdata_o <= mem[bus_i.addr[7:0]];
                rd_cnt_o <= rd_cnt_o + 16'h0001;
                last_rd_ff <= bus_i.addr;
                rd_pend_ff <= 1'b1;
            end
        end
        else
        begin
            ack_o <= 1'b0;
            rdata_o <= ~rdata_o; // released data lines toggle
        end
    end
endmodule

/* File: testbench/tb_bit_manipulation_execute.sv */
// self-checking testbench of the bit manipulation execute block
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb_bit_manipulation_execute;
    import bme_pkg::*;
    typedef struct { bme_kind_e kind; logic [2:0] bpos; logic [7:0] init;
        logic [7:0] res; logic c; logic z; } bme_row_s;
    logic clock_i, nrst_i, instr_valid_i, instr_ready_o, done_o, illegal_o, carry_o, zero_o;
    logic gr_we_i, bus_ack_i, order_err, ill, c_exp, z_exp, wr_k;
    bme_instr_s instr_i;
    bme_bus_s bus_o;
    logic [3:0] gr_idx_i, wait_i;
    logic [7:0] gr_wdata_i, gr_rdata_o, bus_rdata_i, pin_i, pin_o, pin_oe_o, rv, ev;
    logic [15:0] rd_cnt, wr_cnt, r0, w0c;
    int err_total, tests_run;
    // kind, bit, fetched byte, then expected byte, carry and zero after it
    bme_row_s rows [15] = '{'{BME_SET, 3'h7, 8'h00, 8'h80, 1'b0, 1'b0}, '{BME_CLR, 3'h0, 8'hFF, 8'hFE, 1'b0, 1'b0},
        '{BME_INV, 3'h3, 8'hAA, 8'hA2, 1'b0, 1'b0}, '{BME_TST, 3'h0, 8'h01, 8'h01, 1'b0, 1'b0},
        '{BME_TST, 3'h7, 8'h00, 8'h00, 1'b0, 1'b1}, '{BME_LD, 3'h7, 8'h80, 8'h80, 1'b1, 1'b1},
        '{BME_AND, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1}, '{BME_IAND, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1},
        '{BME_XOR, 3'h1, 8'h02, 8'h02, 1'b1, 1'b1}, '{BME_IOR, 3'h6, 8'h00, 8'h00, 1'b1, 1'b1},
        '{BME_IXOR, 3'h5, 8'h00, 8'h00, 1'b0, 1'b1}, '{BME_OR, 3'h4, 8'h10, 8'h10, 1'b1, 1'b1},
        '{BME_ILD, 3'h1, 8'h02, 8'h02, 1'b0, 1'b1}, '{BME_ST, 3'h6, 8'hFF, 8'hBF, 1'b0, 1'b1},
        '{BME_IST, 3'h6, 8'h00, 8'h40, 1'b0, 1'b1}};

    bme_exec bme_exec_i (.clock_i(clock_i), .nrst_i(nrst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .instr_ready_o(instr_ready_o), .done_o(done_o), .illegal_o(illegal_o), .carry_o(carry_o),
        .zero_o(zero_o), .gr_we_i(gr_we_i), .gr_idx_i(gr_idx_i), .gr_wdata_i(gr_wdata_i),
        .gr_rdata_o(gr_rdata_o), .bus_o(bus_o), .bus_rdata_i(bus_rdata_i), .bus_ack_i(bus_ack_i),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
    bme_mem_model bme_mem_model_i (.clock_i(clock_i), .nrst_i(nrst_i), .bus_i(bus_o), .wait_i(wait_i),
        .rdata_o(bus_rdata_i), .ack_o(bus_ack_i), .rd_cnt_o(rd_cnt), .wr_cnt_o(wr_cnt), .order_err_o(order_err));

    // ----------------------------------------
    // clock, watchdog and tasks
    // ----------------------------------------
    initial
    begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    // cut a hang short well after the expected few hundred cycles
    initial
    begin
        repeat (6000) @(posedge clock_i);
        err_total++;
        results();
    end

    task automatic results();
        if (err_total == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // offer one instruction, wait for its done pulse, capture illegal
    task automatic run(input logic [15:0] w0, input logic [15:0] w1);
        int n;
        n = 0;
        instr_i = {w0, w1};
        instr_valid_i = 1'b1;
        while (instr_ready_o !== 1'b1 && n < 50)
        begin
            @(negedge clock_i);
            n++;
        end
        @(negedge clock_i);
        instr_valid_i = 1'b0;
        while (done_o !== 1'b1 && n < 100)
        begin
            @(negedge clock_i);
            n++;
        end
        if (n >= 100)
        begin
            err_total++;
            $display("[FAIL] %0t no done", $time);
        end
        ill = illegal_o;
        @(negedge clock_i);
    endtask

    task automatic set_reg(input logic [3:0] idx, input logic [7:0] d);
        gr_we_i = 1'b1;
        gr_idx_i = idx;
        gr_wdata_i = d;
        @(negedge clock_i);
        gr_we_i = 1'b0;
        @(negedge clock_i);
    endtask

    task automatic get_reg(input logic [3:0] idx);
        gr_idx_i = idx;
        @(negedge clock_i);
        rv = gr_rdata_o;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        err_total = 0;
        tests_run = 0;
        nrst_i = 1'b0;
        instr_valid_i = 1'b0;
        instr_i = '0;
        gr_we_i = 1'b0;
        gr_idx_i = 4'h0;
        gr_wdata_i = 8'h00;
        pin_i = 8'h40;
        wait_i = 4'h0;
        c_exp = 1'b0;
        z_exp = 1'b0;
        repeat (20) @(negedge clock_i);
        nrst_i = 1'b1;
        // every kind on an absolute memory byte, with varied bus stalls
        foreach (rows[i])
        begin
            bme_mem_model_i.mem[8'h10] = rows[i].init;
            wait_i = 4'(i % 3);
            r0 = rd_cnt;
            w0c = wr_cnt;
            wr_k = rows[i].kind inside {BME_SET, BME_CLR, BME_INV, BME_ST, BME_IST};
            {c_exp, z_exp, ev} = {rows[i].c, rows[i].z, rows[i].res};
            run(16'h4010, {4'h7, rows[i].kind, 1'b0, rows[i].bpos, 4'h0});
            `CHK(bme_mem_model_i.mem[8'h10], ev)
            `CHK(carry_o, c_exp)
            `CHK(zero_o, z_exp)
            `CHK(rd_cnt - r0, 16'h0001)
            `CHK(wr_cnt - w0c, {15'h0000, wr_k})
            `CHK(ill, 1'b0)
        end
        `CHK(order_err, 1'b0)
        // reset in mid-run clears flags and pins
        nrst_i = 1'b0;
        repeat (20) @(negedge clock_i);
        nrst_i = 1'b1;
        @(negedge clock_i);
        `CHK({carry_o, zero_o, bus_o.req, instr_ready_o}, 4'h1)
        `CHK({pin_oe_o, pin_o}, 16'h0000)
        // write-only direction byte reads as ones inside read-modify-write
        r0 = rd_cnt;
        run(16'h40C4, {4'h7, BME_CLR, 8'h70});
        `CHK(pin_oe_o, 8'h7F)
        run(16'h40C4, {4'h7, BME_CLR, 8'h00});
        `CHK(pin_oe_o, 8'hFE)
        run(16'h40C4, {4'h7, BME_TST, 8'h00});
        `CHK(zero_o, 1'b0)
        run(16'h40C6, {4'h7, BME_SET, 8'h70});
        `CHK(pin_o, 8'h80)
        `CHK(rd_cnt - r0, 16'h0000)
        // register forms with immediate and register bit numbers
        set_reg(4'h8, 8'h5A);
        run({4'h7, BME_INV, 8'h38}, 16'h0000);
        get_reg(4'h8);
        `CHK(rv, 8'h52)
        set_reg(4'h9, 8'hFD);
        run({4'h6, BME_SET, 8'h98}, 16'h0000);
        get_reg(4'h8);
        `CHK(rv, 8'h72)
        run({4'h6, BME_IAND, 8'h98}, 16'h0000);
        `CHK(ill, 1'b1)
        run({4'h7, BME_TST, 8'h78}, 16'h0000);
        get_reg(4'h8);
        `CHK({zero_o, rv}, 9'h172)
        run(16'h8000, 16'h0000);
        `CHK(ill, 1'b1)
        // indirect form through pointer word FF20 with a slow bus
        set_reg(4'h2, 8'hFF);
        set_reg(4'hA, 8'h20);
        bme_mem_model_i.mem[8'h20] = 8'h81;
        wait_i = 4'h5;
        run(16'h5020, {4'h7, BME_CLR, 8'h71});
        `CHK({ill, bme_mem_model_i.mem[8'h20]}, 9'h181)
        run(16'h5020, {4'h7, BME_CLR, 8'h70});
        `CHK(bme_mem_model_i.mem[8'h20], 8'h01)
        run(16'h5020, {4'h6, BME_INV, 8'h90});
        `CHK(bme_mem_model_i.mem[8'h20], 8'h21)
        run(16'h5020, {4'h6, BME_IST, 8'h90});
        `CHK(ill, 1'b1)
        `CHK(order_err, 1'b0)
        results();
    end
endmodule
